// [hw/cts_defs.vh]
// constants for the camera tone and sync register subset
`ifndef CTS_DEFS_VH
`define CTS_DEFS_VH

// register offsets
`define CTS_OFF_VSYNC_CTRL 8'h21
`define CTS_OFF_LUMA_UPPER 8'h24
`define CTS_OFF_LUMA_LOWER 8'h25
`define CTS_OFF_FAST_THR 8'h26
`define CTS_OFF_LUMA_AVG 8'h2f
`define CTS_OFF_VWIN_OFS 8'h33
`define CTS_OFF_EXP_HIGH 8'h39
`define CTS_OFF_MONITOR 8'h66
`define CTS_OFF_TOP_GRAD 8'h7b
`define CTS_OFF_POINT_1 8'h7c
`define CTS_OFF_POINT_2 8'h7d
`define CTS_OFF_POINT_3 8'h7e
`define CTS_OFF_POINT_4 8'h7f
`define CTS_OFF_POINT_5 8'h80
`define CTS_OFF_POINT_6 8'h81

// reset values
`define CTS_RST_VSYNC_CTRL 8'h00
`define CTS_RST_LUMA_UPPER 8'h78
`define CTS_RST_LUMA_LOWER 8'h68
`define CTS_RST_FAST_THR 8'hd4
`define CTS_RST_LUMA_AVG 8'h00
`define CTS_RST_VWIN_OFS 8'h00
`define CTS_RST_EXP_HIGH 8'h82
`define CTS_RST_MONITOR 8'h00
`define CTS_RST_TOP_GRAD 8'h24
`define CTS_RST_POINT_1 8'h0f
`define CTS_RST_POINT_2 8'h1f
`define CTS_RST_POINT_3 8'h36
`define CTS_RST_POINT_4 8'h54
`define CTS_RST_POINT_5 8'h5f
`define CTS_RST_POINT_6 8'h6a

// field positions
`define CTS_BIT_LINE_ONLY 6
`define CTS_BIT_FIELD_ONE 5
`define CTS_BIT_FIELD_TWO 4
`define CTS_EXP_HIGH_MSB 6
`define CTS_MON_SEL_MSB 7
`define CTS_MON_SEL_LSB 4

// value returned for unmapped offsets
`define CTS_RSVD_READ 8'h00

// tone curve breakpoint input levels
`define CTS_KNOT_1 10'h010
`define CTS_KNOT_2 10'h020
`define CTS_KNOT_3 10'h040
`define CTS_KNOT_4 10'h080
`define CTS_KNOT_5 10'h0a0
`define CTS_KNOT_6 10'h0c0
`define CTS_KNOT_7 10'h0e0
`define CTS_KNOT_8 10'h100
`define CTS_KNOT_9 10'h120
`define CTS_KNOT_10 10'h140
`define CTS_KNOT_11 10'h180
`define CTS_KNOT_12 10'h1c0
`define CTS_KNOT_13 10'h240
`define CTS_KNOT_14 10'h2c0
`define CTS_KNOT_15 10'h340
// the gradient is scaled so that 256 steps of slope span one unit
`define CTS_TOP_SHIFT 4'd8

`endif

// [hw/cts_regs.v]
// camera tone and sync register subset with its attached control logic
`timescale 1ns/1ps
`include "cts_defs.vh"
module cts_regs (
  input wire clk,
  input wire nrst,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // exposure loop
  input wire luma_avg_load,
  input wire [7:0] luma_avg_in,
  input wire fast_mode,
  output reg ae_too_bright,
  output reg ae_too_dark,
  output reg ae_big_step,
  input wire [7:0] exposure_middle_bits,
  input wire exposure_low_bit,
  output reg [15:0] exposure_value,
  // monitor and window
  output wire [3:0] monitor_sel,
  output wire [7:0] vwin_offset,
  // vertical sync
  input wire line_start,
  input wire half_line,
  input wire second_field,
  input wire vsync_due,
  output wire vsync_start,
  // tone curve
  input wire pix_valid,
  input wire [9:0] pix_in,
  input wire [71:0] tone_points_hi,
  output wire [7:0] tone_out,
  output reg tone_valid
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------

  reg [7:0] vsync_pattern_control;
  reg [7:0] luma_upper_limit;
  reg [7:0] luma_lower_limit;
  reg [7:0] fast_step_threshold;
  reg [7:0] luma_average;
  reg [7:0] vertical_window_offset;
  reg [7:0] exposure_high_bits;
  reg [7:0] monitor_select;
  reg [7:0] tone_top_gradient;
  reg [7:0] tone_point_1;
  reg [7:0] tone_point_2;
  reg [7:0] tone_point_3;
  reg [7:0] tone_point_4;
  reg [7:0] tone_point_5;
  reg [7:0] tone_point_6;

  reg [7:0] next_rdata;
  wire [119:0] tone_points;

  // ---------------------------------------------------------------
  // software writes
  // ---------------------------------------------------------------

  // reserved bits are stored as written so the reset value of the
  // exposure high register reads back intact; logic never uses them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vsync_pattern_control <= `CTS_RST_VSYNC_CTRL;
      luma_upper_limit <= `CTS_RST_LUMA_UPPER;
      luma_lower_limit <= `CTS_RST_LUMA_LOWER;
      fast_step_threshold <= `CTS_RST_FAST_THR;
      vertical_window_offset <= `CTS_RST_VWIN_OFS;
      exposure_high_bits <= `CTS_RST_EXP_HIGH;
      monitor_select <= `CTS_RST_MONITOR;
      tone_top_gradient <= `CTS_RST_TOP_GRAD;
      tone_point_1 <= `CTS_RST_POINT_1;
      tone_point_2 <= `CTS_RST_POINT_2;
      tone_point_3 <= `CTS_RST_POINT_3;
      tone_point_4 <= `CTS_RST_POINT_4;
      tone_point_5 <= `CTS_RST_POINT_5;
      tone_point_6 <= `CTS_RST_POINT_6;
    end else if (reg_wr) begin
      case (reg_addr)
        `CTS_OFF_VSYNC_CTRL: begin
          vsync_pattern_control <= reg_wdata;
        end
        `CTS_OFF_LUMA_UPPER: begin
          luma_upper_limit <= reg_wdata;
        end
        `CTS_OFF_LUMA_LOWER: begin
          luma_lower_limit <= reg_wdata;
        end
        `CTS_OFF_FAST_THR: begin
          fast_step_threshold <= reg_wdata;
        end
        `CTS_OFF_VWIN_OFS: begin
          vertical_window_offset <= reg_wdata;
        end
        `CTS_OFF_EXP_HIGH: begin
          exposure_high_bits <= reg_wdata;
        end
        `CTS_OFF_MONITOR: begin
          monitor_select <= reg_wdata;
        end
        `CTS_OFF_TOP_GRAD: begin
          tone_top_gradient <= reg_wdata;
        end
        `CTS_OFF_POINT_1: begin
          tone_point_1 <= reg_wdata;
        end
        `CTS_OFF_POINT_2: begin
          tone_point_2 <= reg_wdata;
        end
        `CTS_OFF_POINT_3: begin
          tone_point_3 <= reg_wdata;
        end
        `CTS_OFF_POINT_4: begin
          tone_point_4 <= reg_wdata;
        end
        `CTS_OFF_POINT_5: begin
          tone_point_5 <= reg_wdata;
        end
        `CTS_OFF_POINT_6: begin
          tone_point_6 <= reg_wdata;
        end
        default: begin
          // reserved offsets: write has no effect
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // luminance average
  // ---------------------------------------------------------------

  // a fresh measurement wins over a software write in the same cycle,
  // so the loop never acts on a stale value written over a new one
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      luma_average <= `CTS_RST_LUMA_AVG;
    else if (luma_avg_load)
      luma_average <= luma_avg_in;
    else if (reg_wr && reg_addr == `CTS_OFF_LUMA_AVG)
      luma_average <= reg_wdata;
  end

  // ---------------------------------------------------------------
  // software reads
  // ---------------------------------------------------------------

  always @* begin
    case (reg_addr)
      `CTS_OFF_VSYNC_CTRL: next_rdata = vsync_pattern_control;
      `CTS_OFF_LUMA_UPPER: next_rdata = luma_upper_limit;
      `CTS_OFF_LUMA_LOWER: next_rdata = luma_lower_limit;
      `CTS_OFF_FAST_THR: next_rdata = fast_step_threshold;
      `CTS_OFF_LUMA_AVG: next_rdata = luma_average;
      `CTS_OFF_VWIN_OFS: next_rdata = vertical_window_offset;
      `CTS_OFF_EXP_HIGH: next_rdata = exposure_high_bits;
      `CTS_OFF_MONITOR: next_rdata = monitor_select;
      `CTS_OFF_TOP_GRAD: next_rdata = tone_top_gradient;
      `CTS_OFF_POINT_1: next_rdata = tone_point_1;
      `CTS_OFF_POINT_2: next_rdata = tone_point_2;
      `CTS_OFF_POINT_3: next_rdata = tone_point_3;
      `CTS_OFF_POINT_4: next_rdata = tone_point_4;
      `CTS_OFF_POINT_5: next_rdata = tone_point_5;
      `CTS_OFF_POINT_6: next_rdata = tone_point_6;
      default: next_rdata = `CTS_RSVD_READ;
    endcase
  end

  // read data holds between reads so a slow serial engine can
  // shift it out at its own pace
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // exposure and gain targets
  // ---------------------------------------------------------------

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ae_too_bright <= 1'b0;
      ae_too_dark <= 1'b0;
      ae_big_step <= 1'b0;
    end else begin
      ae_too_bright <= luma_average > luma_upper_limit;
      ae_too_dark <= luma_average < luma_lower_limit;
      // large steps only in fast mode and only at or above the threshold
      ae_big_step <= fast_mode &&
                     luma_average >= fast_step_threshold;
    end
  end

  // ---------------------------------------------------------------
  // exposure value assembly
  // ---------------------------------------------------------------

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      exposure_value <= 16'h0000;
    else
      exposure_value <= {exposure_high_bits[`CTS_EXP_HIGH_MSB:0],
                         exposure_middle_bits,
                         exposure_low_bit};
  end

  // ---------------------------------------------------------------
  // monitor and window
  // ---------------------------------------------------------------

  assign monitor_sel =
    monitor_select[`CTS_MON_SEL_MSB:`CTS_MON_SEL_LSB];
  assign vwin_offset = vertical_window_offset;

  // ---------------------------------------------------------------
  // vertical sync gating
  // ---------------------------------------------------------------

  cts_vsync_gate u_vsync (
    .clk(clk),
    .nrst(nrst),
    .line_only(vsync_pattern_control[`CTS_BIT_LINE_ONLY]),
    .field_one_only(vsync_pattern_control[`CTS_BIT_FIELD_ONE]),
    .field_two_only(vsync_pattern_control[`CTS_BIT_FIELD_TWO]),
    .line_start(line_start),
    .half_line(half_line),
    .second_field(second_field),
    .vsync_due(vsync_due),
    .vsync_start(vsync_start)
  );

  // ---------------------------------------------------------------
  // tone curve
  // ---------------------------------------------------------------

  // breakpoints seven to fifteen live in the neighbouring bank
  assign tone_points = {tone_points_hi,
                        tone_point_6,
                        tone_point_5,
                        tone_point_4,
                        tone_point_3,
                        tone_point_2,
                        tone_point_1};

  // the slope is taken as written; software owns its derivation
  cts_tone_curve u_tone (
    .clk(clk),
    .nrst(nrst),
    .pix_in(pix_in),
    .points(tone_points),
    .gradient(tone_top_gradient),
    .tone_out(tone_out)
  );

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tone_valid <= 1'b0;
    else
      tone_valid <= pix_valid;
  end

endmodule

// [hw/cts_tone_curve.v]
// piecewise linear tone curve over fifteen breakpoints and a top slope
`timescale 1ns/1ps
`include "cts_defs.vh"
module cts_tone_curve (
  input wire clk,
  input wire nrst,
  input wire [9:0] pix_in,
  input wire [119:0] points,
  input wire [7:0] gradient,
  output reg [7:0] tone_out
);

  function [9:0] knot_x;
    input [3:0] k;
    begin
      case (k)
        4'd1: knot_x = `CTS_KNOT_1;
        4'd2: knot_x = `CTS_KNOT_2;
        4'd3: knot_x = `CTS_KNOT_3;
        4'd4: knot_x = `CTS_KNOT_4;
        4'd5: knot_x = `CTS_KNOT_5;
        4'd6: knot_x = `CTS_KNOT_6;
        4'd7: knot_x = `CTS_KNOT_7;
        4'd8: knot_x = `CTS_KNOT_8;
        4'd9: knot_x = `CTS_KNOT_9;
        4'd10: knot_x = `CTS_KNOT_10;
        4'd11: knot_x = `CTS_KNOT_11;
        4'd12: knot_x = `CTS_KNOT_12;
        4'd13: knot_x = `CTS_KNOT_13;
        4'd14: knot_x = `CTS_KNOT_14;
        4'd15: knot_x = `CTS_KNOT_15;
        default: knot_x = 10'h000;
      endcase
    end
  endfunction

  // log2 of each segment width; all widths are powers of two
  function [3:0] seg_shift;
    input [3:0] s;
    begin
      case (s)
        4'd0, 4'd1: seg_shift = 4'd4;
        4'd2, 4'd4, 4'd5, 4'd6, 4'd7, 4'd8, 4'd9: seg_shift = 4'd5;
        4'd3, 4'd10, 4'd11: seg_shift = 4'd6;
        default: seg_shift = 4'd7;
      endcase
    end
  endfunction

  wire [127:0] ys;
  reg [3:0] seg;
  reg top;
  reg [3:0] k;
  reg [7:0] ya;
  reg [7:0] yb;
  reg [9:0] dx;
  reg signed [8:0] dy;
  reg signed [20:0] step;
  reg signed [20:0] sum;
  reg [17:0] top_prod;
  integer i;

  assign ys = {points, 8'h00};

  always @* begin
    top = 1'b1;
    seg = 4'd0;
    k = 4'd0;
    for (i = 14; i >= 0; i = i - 1) begin
      k = i[3:0];
      if (pix_in < knot_x(k + 4'd1)) begin
        seg = k;
        top = 1'b0;
      end
    end
    ya = ys[{seg, 3'b000} +: 8];
    yb = ys[{seg + 4'd1, 3'b000} +: 8];
    dx = pix_in - knot_x(top ? 4'd15 : seg);
    dy = $signed({1'b0, yb}) - $signed({1'b0, ya});
    // full-width product so a steep slope far above the last knot
    // is not cut before the shift
    top_prod = {10'h000, gradient} * {8'h00, dx};
    if (top) begin
      ya = ys[120 +: 8];
      step = $signed({3'b000, top_prod}) >>> `CTS_TOP_SHIFT;
    end else begin
      step = (dy * $signed({1'b0, dx})) >>> seg_shift(seg);
    end
    sum = $signed({13'h0000, ya}) + step;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      tone_out <= 8'h00;
    else if (sum < 0)
      tone_out <= 8'h00;
    else if (sum > 21'sd255)
      tone_out <= 8'hff;
    else
      tone_out <= sum[7:0];
  end

endmodule

// [hw/cts_vsync_gate.v]
// vertical sync start gating by line boundary and field
`timescale 1ns/1ps
module cts_vsync_gate (
  input wire clk,
  input wire nrst,
  input wire line_only,
  input wire field_one_only,
  input wire field_two_only,
  input wire line_start,
  input wire half_line,
  input wire second_field,
  input wire vsync_due,
  output reg vsync_start
);

  reg started;
  wire boundary_ok;
  wire field_ok;
  wire fire;

  assign boundary_ok = line_start | (~line_only & half_line);
  // both field bits set leaves no field allowed: pulse suppressed
  assign field_ok = (~field_one_only | ~second_field) &
                    (~field_two_only | second_field);
  assign fire = vsync_due & ~started & boundary_ok & field_ok;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vsync_start <= 1'b0;
      started <= 1'b0;
    end else begin
      vsync_start <= fire;
      // one start per due interval; rearm once due drops
      if (!vsync_due)
        started <= 1'b0;
      else if (fire)
        started <= 1'b1;
    end
  end

endmodule

// [testbench/cts_host.sv]
// host model on the parallel register port
`timescale 1ns/1ps
module cts_host (
  input wire clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // idle lines carry the inverse so a stale value is never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = dv;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~dv;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] dv,
                    output logic vv);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    dv = reg_rdata;
    vv = reg_rvalid;
  endtask
  // clamped because a low last point overflows the byte
  function automatic logic [7:0] slope(input logic [7:0] p15);
    logic [15:0] s;
    s = (16'h0100 - p15) * 16'h0040 / 16'h0030;
    return s > 16'h00ff ? 8'hff : s[7:0];
  endfunction
endmodule

// [testbench/cts_regs_asserts.sv]
// port assertions for the camera tone and sync register subset
`timescale 1ns/1ps
`include "cts_defs.vh"
module cts_regs_chk (
  input wire clk,
  input wire nrst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire fast_mode,
  input wire ae_big_step,
  input wire [7:0] exposure_middle_bits,
  input wire exposure_low_bit,
  input wire [15:0] exposure_value,
  input wire [3:0] monitor_sel,
  input wire line_start,
  input wire half_line,
  input wire vsync_due,
  input wire vsync_start,
  input wire pix_valid,
  input wire tone_valid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // --------------------------------
  // one pulse per due interval
  // --------------------------------
  reg seen;
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      seen <= 1'b0;
    else if (!vsync_due)
      seen <= 1'b0;
    else if (vsync_start)
      seen <= 1'b1;
  end
  a_vsync_once: assert property (vsync_start |-> !seen)
    else $error("second vsync in one due interval");
  a_vsync_pulse: assert property (vsync_start |=> !vsync_start)
    else $error("vsync pulse longer than one cycle");
  a_vsync_cause: assert property (vsync_start |-> $past(vsync_due) &&
    ($past(line_start) || $past(half_line)))
    else $error("vsync without due boundary");
  a_rvalid_follows: assert property (1'b1 |=> reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after read");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_exp_low_join: assert property (1'b1 |=> exposure_value[8:0] ==
    $past({exposure_middle_bits, exposure_low_bit}))
    else $error("exposure low part wrong");
  a_exp_high_hold: assert property (!reg_wr [*2] |=>
    $stable(exposure_value[15:9]))
    else $error("exposure high part moved without write");
  a_mon_sel_write: assert property (reg_wr &&
    reg_addr == `CTS_OFF_MONITOR |=> monitor_sel == $past(reg_wdata[7:4]))
    else $error("monitor select not updated");
  a_big_step_mode: assert property (!fast_mode |=> !ae_big_step)
    else $error("large step outside fast mode");
  a_tone_valid: assert property (1'b1 |=> tone_valid == $past(pix_valid))
    else $error("tone valid not delayed one cycle");
endmodule
bind cts_regs cts_regs_chk cts_regs_chk_i (.*);

// [testbench/tb.sv]
// self-checking bench for the register subset
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic luma_avg_load = 1'b0, fast_mode = 1'b0, exposure_low_bit = 1'b0;
  logic line_start = 1'b0, half_line = 1'b0, second_field = 1'b0;
  logic vsync_due = 1'b0, pix_valid = 1'b0;
  logic [7:0] luma_avg_in = 8'h00, exposure_middle_bits = 8'h00;
  logic [9:0] pix_in = 10'h000;
  logic [71:0] tone_points_hi = 72'h0;
  wire reg_wr, reg_rd, reg_rvalid, ae_too_bright, ae_too_dark;
  wire ae_big_step, vsync_start, tone_valid;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, vwin_offset, tone_out;
  wire [3:0] monitor_sel;
  wire [15:0] exposure_value;
  int bad_count = 0, samples_checked = 0;
  logic [31:0] seed = 32'hcf01, r;
  logic [7:0] d, w, g, p [0:15];
  logic v, e;
  logic [7:0] offs [0:14] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h2f, 8'h33,
    8'h39, 8'h66, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f, 8'h80, 8'h81};
  logic [7:0] defs [0:14] = '{8'h00, 8'h78, 8'h68, 8'hd4, 8'h00, 8'h00,
    8'h82, 8'h00, 8'h24, 8'h0f, 8'h1f, 8'h36, 8'h54, 8'h5f, 8'h6a};
  logic [7:0] rsv [0:6] = '{8'h22, 8'h2e, 8'h30, 8'h3a, 8'h65, 8'h7a, 8'h82};
  logic [9:0] knot [0:15] = '{10'h000, 10'h010, 10'h020, 10'h040, 10'h080,
    10'h0a0, 10'h0c0, 10'h0e0, 10'h100, 10'h120, 10'h140, 10'h180, 10'h1c0,
    10'h240, 10'h2c0, 10'h340};
  always #12.5 clk = ~clk;
  cts_regs cts_regs_i (.*);
  cts_host cts_host_i (.*);
  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [7:0] tone_exp(input logic [9:0] x);
    int k, y;
    k = 0;
    for (int i = 1; i < 15; i++)
      if (x >= knot[i])
        k = i;
    if (x >= 10'h340)
      y = int'(p[15]) + ((int'(g) * (int'(x) - 832)) >>> 8);
    else
      y = int'(p[k]) + (((int'(p[k + 1]) - int'(p[k])) *
        (int'(x) - int'(knot[k]))) >>> $clog2(knot[k + 1] - knot[k]));
    return y > 255 ? 8'hff : y[7:0];
  endfunction
  task automatic chk(input logic [15:0] gv, input logic [15:0] ev);
    samples_checked++;
    if (gv !== ev) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, gv, ev);
    end
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #250000;
    bad_count++;
    wrap_up();
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    chk({monitor_sel, vwin_offset}, 12'h000);
    for (int i = 0; i < 15; i++) begin
      cts_host_i.rd(offs[i], d, v);
      chk({v, d}, {1'b1, defs[i]});
      r = rnd();
      cts_host_i.wr(offs[i], r[7:0]);
      cts_host_i.rd(offs[i], d, v);
      chk(d, r[7:0]);
    end
    r = rnd();
    cts_host_i.wr(8'h33, r[7:0]);
    cts_host_i.wr(8'h66, r[15:8]);
    chk({monitor_sel, vwin_offset}, {r[15:12], r[7:0]});
    for (int i = 0; i < 7; i++) begin
      cts_host_i.wr(rsv[i], 8'h5a);
      cts_host_i.rd(rsv[i], d, v);
      chk(d, 8'h00);
    end
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      cts_host_i.wr(8'h24, r[7:0]);
      cts_host_i.wr(8'h25, r[15:8]);
      cts_host_i.wr(8'h26, r[23:16]);
      // equal values probe the inclusive and exclusive compares
      w = i % 4 == 0 ? r[7:0] : i % 4 == 1 ? r[15:8] :
        i % 4 == 2 ? r[23:16] : r[31:24];
      @(negedge clk);
      luma_avg_load = 1'b1;
      luma_avg_in = w;
      fast_mode = i[2];
      @(negedge clk);
      luma_avg_load = 1'b0;
      repeat (2) @(negedge clk);
      chk(ae_too_bright, w > r[7:0]);
      chk(ae_too_dark, w < r[15:8]);
      chk(ae_big_step, fast_mode && w >= r[23:16]);
    end
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      cts_host_i.wr(8'h39, r[7:0]);
      exposure_middle_bits = r[15:8];
      exposure_low_bit = r[16];
      repeat (3) @(negedge clk);
      chk(exposure_value, {r[6:0], r[15:8], r[16]});
    end
    for (int i = 0; i < 32; i++) begin
      cts_host_i.wr(8'h21, {1'b0, i[4:2], 4'h0});
      e = (i[0] | !i[4]) & !(i[3] & i[1]) & !(i[2] & !i[1]);
      repeat (2) begin
        @(negedge clk);
        vsync_due = 1'b1;
        second_field = i[1];
        line_start = i[0];
        half_line = !i[0];
        @(negedge clk);
        line_start = 1'b0;
        half_line = 1'b0;
        chk(vsync_start, e);
        e = 1'b0;
      end
      vsync_due = 1'b0;
    end
    p[0] = 8'h00;
    for (int n = 0; n < 2; n++) begin
      for (int i = 1; i < 16; i++) begin
        r = rnd();
        p[i] = r[7:0];
        if (i < 7)
          cts_host_i.wr(offs[8 + i], p[i]);
        else
          tone_points_hi[8 * i - 56 +: 8] = p[i];
      end
      g = cts_host_i.slope(p[15]);
      cts_host_i.wr(8'h7b, g);
      for (int i = 0; i < 120; i++) begin
        r = rnd();
        @(negedge clk);
        pix_in = i < 16 ? knot[i] : i == 16 ? 10'h3ff : r[9:0];
        pix_valid = 1'b1;
        @(negedge clk);
        chk(tone_out, tone_exp(pix_in));
        chk(tone_valid, 1'b1);
      end
    end
    pix_valid = 1'b0;
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    chk(tone_valid, 1'b0);
    cts_host_i.rd(8'h7b, d, v);
    chk(d, 8'h24);
    wrap_up();
  end
endmodule
